// ==== ipcb_cfg.svh ====
// Constants of the interrupt priority configuration bank.
// Assumes inclusion by bare name from every file that needs them.
`ifndef IPCB_CFG_SVH
`define IPCB_CFG_SVH

// =====================================================
// Sizes
`define IPCB_NUM_SRC 18
`define IPCB_NUM_GRP 5
`define IPCB_ADDR_W 4
`define IPCB_DATA_W 16

// =====================================================
// Register addresses
`define IPCB_ADDR_GRP2 4'h2
`define IPCB_ADDR_GRP3 4'h3
`define IPCB_ADDR_GRP4 4'h4
`define IPCB_ADDR_GRP5 4'h5
`define IPCB_ADDR_GRP6 4'h6
`define IPCB_ADDR_ACT_LO 4'h8
`define IPCB_ADDR_ACT_HI 4'h9

// =====================================================
// Group slots in the decode vector
`define IPCB_GRP_2 3'h0
`define IPCB_GRP_3 3'h1
`define IPCB_GRP_4 3'h2
`define IPCB_GRP_5 3'h3
`define IPCB_GRP_6 3'h4

// =====================================================
// Field positions (lowest bit of each 3-bit field)
`define IPCB_LSB_HI 4'hC
`define IPCB_LSB_MH 4'h8
`define IPCB_LSB_ML 4'h4
`define IPCB_LSB_LO 4'h0

// =====================================================
// Implemented bits of each group and reset values
`define IPCB_MASK_GRP2 16'h7777
`define IPCB_MASK_GRP3 16'h0777
`define IPCB_MASK_GRP4 16'h7777
`define IPCB_MASK_GRP5 16'h7707
`define IPCB_MASK_GRP6 16'h7777
`define IPCB_LEVEL_RESET 3'h4
`define IPCB_LEVEL_OFF 3'h0
`define IPCB_RDATA_IDLE 16'h0000

`endif

// ==== ipcb_field.sv ====
// One 3-bit priority field register.
// Assumes a write strobe already decoded for this field's register.
`timescale 1ns/1ps
`include "ipcb_cfg.svh"

module ipcb_field (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_wr,
    input wire ipcb_pkg::ipcb_level_t i_wdata,
    output ipcb_pkg::ipcb_level_t o_level
);
    import ipcb_pkg::*;

    ipcb_level_t level_q;

    // Field storage, starts at level 4
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            level_q <= `IPCB_LEVEL_RESET;
        end else if (i_wr) begin
            level_q <= i_wdata;
        end
    end

    assign o_level = level_q;
endmodule

// ==== ipcb_gate.sv ====
// Presents one source's priority to the arbitration logic.
// Assumes the level input comes from a field register on the same clock.
`timescale 1ns/1ps
`include "ipcb_cfg.svh"

module ipcb_gate (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire ipcb_pkg::ipcb_level_t i_level,
    output ipcb_pkg::ipcb_level_t o_level,
    output logic o_active
);
    import ipcb_pkg::*;

    ipcb_level_t level_q;
    logic active_q;

    // Level passes as is; zero marks the source as switched off
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            level_q <= `IPCB_LEVEL_RESET;
            active_q <= 1'b1;
        end else begin
            level_q <= i_level;
            active_q <= (i_level != `IPCB_LEVEL_OFF);
        end
    end

    assign o_level = level_q;
    assign o_active = active_q;
endmodule

// ==== ipcb_pkg.sv ====
// Types of the interrupt priority configuration bank.
// Assumes nothing beyond a SystemVerilog compiler.
package ipcb_pkg;

    // =====================================================
    // Priority level of one source
    typedef logic [2:0] ipcb_level_t;

    // =====================================================
    // Sources, in register and field order
    typedef enum {
        SRC_UART1_RX, SRC_SPI1_EVENT, SRC_SPI1_ERROR, SRC_TIMER3,
        SRC_DMA_CH1_DONE, SRC_ADC1_DONE, SRC_UART1_TX,
        SRC_CHANGE_NOTIFY, SRC_COMPARATOR, SRC_I2C1_MASTER, SRC_I2C1_SLAVE,
        SRC_CAPTURE8, SRC_CAPTURE7, SRC_EXT_IRQ1,
        SRC_TIMER4, SRC_COMPARE4, SRC_COMPARE3, SRC_DMA_CH2_DONE
    } ipcb_src_t;

endpackage

// ==== ipcb_properties.sv ====
// Concurrent checks on the priority bank's register port and level outputs.
// Assumes binding to ipcb_top; a few sources stand as samples for all.
`timescale 1ns/1ps
`include "ipcb_cfg.svh"

module ipcb_properties (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [`IPCB_ADDR_W-1:0] i_addr,
    input wire logic [`IPCB_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [`IPCB_DATA_W-1:0] o_rdata,
    input wire ipcb_pkg::ipcb_level_t o_uart1_rx_level,
    input wire ipcb_pkg::ipcb_level_t o_timer3_level,
    input wire ipcb_pkg::ipcb_level_t o_capture7_level,
    input wire ipcb_pkg::ipcb_level_t o_ext_irq1_level,
    input wire ipcb_pkg::ipcb_level_t o_dma_ch2_done_level,
    input wire logic o_uart1_rx_active
);
    import ipcb_pkg::*;

    // =====================================================
    // Helpers
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    logic wr_grp2;
    ipcb_level_t wdata_top;
    // Write to group 2 and the data of its top field
    assign wr_grp2 = i_wr && (i_addr == `IPCB_ADDR_GRP2);
    assign wdata_top = i_wdata[14:12];

    // Bits that may read as one at each address
    function automatic logic [15:0] mask_of(input logic [3:0] a);
        case (a)
            `IPCB_ADDR_GRP2, `IPCB_ADDR_GRP4, `IPCB_ADDR_GRP6: mask_of = `IPCB_MASK_GRP2;
            `IPCB_ADDR_GRP3: mask_of = `IPCB_MASK_GRP3;
            `IPCB_ADDR_GRP5: mask_of = `IPCB_MASK_GRP5;
            `IPCB_ADDR_ACT_LO: mask_of = 16'hFFFF;
            `IPCB_ADDR_ACT_HI: mask_of = 16'h0003;
            default: mask_of = 16'h0000;
        endcase
    endfunction

    // =====================================================
    // Assertions
    a_rdata_idle: assert property (!i_rd |=> o_rdata == `IPCB_RDATA_IDLE)
        else $error("read data not zero outside a read answer");
    a_unimpl_zero: assert property (i_rd |=> (o_rdata & ~mask_of($past(i_addr))) == 16'h0000)
        else $error("unimplemented bit read as one");
    a_write_level: assert property (wr_grp2 |-> ##2 o_uart1_rx_level == $past(wdata_top, 2))
        else $error("written level not presented two cycles later");
    a_active_match: assert property (o_uart1_rx_active == (o_uart1_rx_level != `IPCB_LEVEL_OFF))
        else $error("active flag disagrees with level");
    a_level_hold: assert property (!wr_grp2 |-> ##2 $stable(o_uart1_rx_level))
        else $error("level changed without a write");
    a_readback_grp6: assert property (i_rd && i_addr == `IPCB_ADDR_GRP6
        |=> o_rdata[2:0] == o_dma_ch2_done_level)
        else $error("group 6 low field differs from its level output");
    a_readback_grp5: assert property (i_rd && i_addr == `IPCB_ADDR_GRP5
        |=> o_rdata[2:0] == o_ext_irq1_level && o_rdata[10:8] == o_capture7_level)
        else $error("group 5 fields differ from their level outputs");
    a_reset_level: assert property ($fell(i_reset) |->
        o_uart1_rx_level == `IPCB_LEVEL_RESET && o_timer3_level == `IPCB_LEVEL_RESET)
        else $error("level after reset is not four");

    // Main scenarios
    c_write_grp2: cover property (wr_grp2);
    c_level_off: cover property (o_uart1_rx_level == `IPCB_LEVEL_OFF);
    c_read_grp5: cover property (i_rd && i_addr == `IPCB_ADDR_GRP5);
endmodule

bind ipcb_top ipcb_properties u_props (.*);

// ==== ipcb_tb_top.sv ====
// Self-checking bench of the interrupt priority configuration bank.
// Assumes ipcb_top with its checker bound; drives the register port directly.
`timescale 1ns/1ps
`include "ipcb_cfg.svh"

module ipcb_tb_top;
    import ipcb_pkg::*;

    // =====================================================
    // Clock, reset, port signals
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [3:0] i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [15:0] o_rdata;
    ipcb_level_t lv [18];
    logic [17:0] act;
    logic [53:0] lv_all;
    logic [53:0] exp_lv;
    logic [17:0] exp_act;
    logic [15:0] m [2:6];
    logic [15:0] rd_q;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    typedef struct {logic [3:0] a; logic [15:0] w; logic [15:0] e;} ipcb_row_t;
    ipcb_row_t rows [12] = '{
        '{4'h2, 16'hFFFF, 16'h7777}, '{4'h3, 16'hFFFF, 16'h0777}, '{4'h4, 16'hFFFF, 16'h7777},
        '{4'h5, 16'hFFFF, 16'h7707}, '{4'h6, 16'hFFFF, 16'h7777}, '{4'h2, 16'h0000, 16'h0000},
        '{4'h2, 16'h1234, 16'h1234}, '{4'h4, 16'h5670, 16'h5670}, '{4'h6, 16'h8123, 16'h0123},
        '{4'h5, 16'h3AF9, 16'h3201}, '{4'h3, 16'hF321, 16'h0321}, '{4'hA, 16'hFFFF, 16'h0000}};

    initial begin
        forever #2 i_clk = ~i_clk;
    end

    ipcb_top dut (
        .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_uart1_rx_level(lv[0]), .o_spi1_event_level(lv[1]), .o_spi1_error_level(lv[2]),
        .o_timer3_level(lv[3]), .o_dma_ch1_done_level(lv[4]), .o_adc1_done_level(lv[5]),
        .o_uart1_tx_level(lv[6]), .o_change_notify_level(lv[7]),
        .o_comparator_level(lv[8]), .o_i2c1_master_level(lv[9]),
        .o_i2c1_slave_level(lv[10]), .o_capture8_level(lv[11]), .o_capture7_level(lv[12]),
        .o_ext_irq1_level(lv[13]), .o_timer4_level(lv[14]), .o_compare4_level(lv[15]),
        .o_compare3_level(lv[16]), .o_dma_ch2_done_level(lv[17]),
        .o_uart1_rx_active(act[0]), .o_spi1_event_active(act[1]),
        .o_spi1_error_active(act[2]), .o_timer3_active(act[3]),
        .o_dma_ch1_done_active(act[4]), .o_adc1_done_active(act[5]),
        .o_uart1_tx_active(act[6]), .o_change_notify_active(act[7]),
        .o_comparator_active(act[8]), .o_i2c1_master_active(act[9]),
        .o_i2c1_slave_active(act[10]), .o_capture8_active(act[11]),
        .o_capture7_active(act[12]), .o_ext_irq1_active(act[13]),
        .o_timer4_active(act[14]), .o_compare4_active(act[15]),
        .o_compare3_active(act[16]), .o_dma_ch2_done_active(act[17])
    );

    // Expected levels from the register model, source 0 lowest
    always_comb begin
        lv_all = {<<3{lv}};
        exp_lv = {m[6][2:0], m[6][6:4], m[6][10:8], m[6][14:12], m[5][2:0], m[5][10:8],
            m[5][14:12], m[4][2:0], m[4][6:4], m[4][10:8], m[4][14:12], m[3][2:0],
            m[3][6:4], m[3][10:8], m[2][2:0], m[2][6:4], m[2][10:8], m[2][14:12]};
        for (int i = 0; i < 18; i++) begin
            exp_act[i] = |exp_lv[3*i +: 3];
        end
    end

    // =====================================================
    // Tasks: bus cycles, comparison, verdict
    task automatic check(input string what, input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        i_wr <= 1'b1;
        i_rd <= 1'b0;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
    endtask

    task automatic rd(input logic [3:0] a);
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        rd_q = o_rdata;
        @(posedge i_clk);
    endtask

    // Reads every register and compares levels, flags and the active map
    task automatic verify();
        for (int a = 2; a <= 6; a++) begin
            rd(4'(a));
            check("group readback", 64'(rd_q), 64'(m[a]));
        end
        check("levels", 64'(lv_all), 64'(exp_lv));
        check("active", 64'(act), 64'(exp_act));
        rd(`IPCB_ADDR_ACT_LO);
        check("active map low", 64'(rd_q), 64'(exp_act[15:0]));
        rd(`IPCB_ADDR_ACT_HI);
        check("active map high", 64'(rd_q), 64'(exp_act[17:16]));
    endtask

    task automatic load_reset_model();
        m[2] = 16'h4444;
        m[3] = 16'h0444;
        m[4] = 16'h4444;
        m[5] = 16'h4404;
        m[6] = 16'h4444;
    endtask

    task automatic results();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Cuts a hang short
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            results();
        end
    end

    // =====================================================
    // Main sequence
    initial begin
        load_reset_model();
        repeat (6) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        verify();
        $display("test reset values done");
        foreach (rows[r]) begin
            wr(rows[r].a, rows[r].w);
            rd(rows[r].a);
            check("row readback", 64'(rd_q), 64'(rows[r].e));
            if (rows[r].a >= 4'h2 && rows[r].a <= 4'h6) begin
                m[rows[r].a] = rows[r].e;
            end
            verify();
        end
        $display("test table rows done");
        // Read-only active map ignores writes; back-to-back writes then read
        wr(`IPCB_ADDR_ACT_LO, 16'h0000);
        wr(4'h2, 16'h7000);
        wr(4'h2, 16'h0007);
        rd(4'h2);
        check("back to back", 64'(rd_q), 64'(16'h0007));
        m[2] = 16'h0007;
        verify();
        $display("test back to back done");
        // Reset in mid-run returns every field to level four
        i_reset <= 1'b1;
        @(posedge i_clk);
        #1;
        load_reset_model();
        #0;
        check("levels in reset", 64'(lv_all), 64'(exp_lv));
        @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        verify();
        $display("test mid-run reset done");
        results();
    end
endmodule

// ==== ipcb_top.sv ====
// Interrupt priority configuration bank: five 16-bit registers of
// 3-bit priority fields, one field per peripheral interrupt source.
// Assumes a single-cycle register port on i_clk and an arbiter outside
// that reads the level and active outputs.
// Levels reach the arbiter one clock after the field register, so a
// read issued right after a write returns the new value on the same edge as the level output.
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "ipcb_cfg.svh"

module ipcb_top (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Register port
    input wire logic [`IPCB_ADDR_W-1:0] i_addr,
    input wire logic [`IPCB_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [`IPCB_DATA_W-1:0] o_rdata,
    // Priority levels to the arbiter, one per source
    output ipcb_pkg::ipcb_level_t o_uart1_rx_level,
    output ipcb_pkg::ipcb_level_t o_spi1_event_level,
    output ipcb_pkg::ipcb_level_t o_spi1_error_level,
    output ipcb_pkg::ipcb_level_t o_timer3_level,
    output ipcb_pkg::ipcb_level_t o_dma_ch1_done_level,
    output ipcb_pkg::ipcb_level_t o_adc1_done_level,
    output ipcb_pkg::ipcb_level_t o_uart1_tx_level,
    output ipcb_pkg::ipcb_level_t o_change_notify_level,
    output ipcb_pkg::ipcb_level_t o_comparator_level,
    output ipcb_pkg::ipcb_level_t o_i2c1_master_level,
    output ipcb_pkg::ipcb_level_t o_i2c1_slave_level,
    output ipcb_pkg::ipcb_level_t o_capture8_level,
    output ipcb_pkg::ipcb_level_t o_capture7_level,
    output ipcb_pkg::ipcb_level_t o_ext_irq1_level,
    output ipcb_pkg::ipcb_level_t o_timer4_level,
    output ipcb_pkg::ipcb_level_t o_compare4_level,
    output ipcb_pkg::ipcb_level_t o_compare3_level,
    output ipcb_pkg::ipcb_level_t o_dma_ch2_done_level,
    // Enable flags to the arbiter, one per source
    output logic o_uart1_rx_active,
    output logic o_spi1_event_active,
    output logic o_spi1_error_active,
    output logic o_timer3_active,
    output logic o_dma_ch1_done_active,
    output logic o_adc1_done_active,
    output logic o_uart1_tx_active,
    output logic o_change_notify_active,
    output logic o_comparator_active,
    output logic o_i2c1_master_active,
    output logic o_i2c1_slave_active,
    output logic o_capture8_active,
    output logic o_capture7_active,
    output logic o_ext_irq1_active,
    output logic o_timer4_active,
    output logic o_compare4_active,
    output logic o_compare3_active,
    output logic o_dma_ch2_done_active
);
    import ipcb_pkg::*;

    // =====================================================
    // Declarations

    // Address decode lines
    logic [`IPCB_NUM_GRP-1:0] grp_hit;
    logic act_lo_hit;
    logic act_hi_hit;

    // Field registers and the copies the arbiter sees
    ipcb_level_t fld_level [`IPCB_NUM_SRC];
    ipcb_level_t out_level [`IPCB_NUM_SRC];
    logic [`IPCB_NUM_SRC-1:0] out_active;

    // Read-back words and read data
    logic [`IPCB_DATA_W-1:0] img [`IPCB_NUM_GRP];
    logic [`IPCB_DATA_W-1:0] act_lo_word;
    logic [`IPCB_DATA_W-1:0] act_hi_word;
    logic [`IPCB_DATA_W-1:0] rd_word;
    logic [`IPCB_DATA_W-1:0] rdata_d;
    logic [`IPCB_DATA_W-1:0] rdata_q;

    // =====================================================
    // Field placement

    // Group slot that holds a source's field
    function automatic logic [2:0] src_grp(input int idx);
        logic [2:0] g;
        g = `IPCB_GRP_2;
        case (ipcb_src_t'(idx))
            SRC_UART1_RX: g = `IPCB_GRP_2;
            SRC_SPI1_EVENT: g = `IPCB_GRP_2;
            SRC_SPI1_ERROR: g = `IPCB_GRP_2;
            SRC_TIMER3: g = `IPCB_GRP_2;
            SRC_DMA_CH1_DONE: g = `IPCB_GRP_3;
            SRC_ADC1_DONE: g = `IPCB_GRP_3;
            SRC_UART1_TX: g = `IPCB_GRP_3;
            SRC_CHANGE_NOTIFY: g = `IPCB_GRP_4;
            SRC_COMPARATOR: g = `IPCB_GRP_4;
            SRC_I2C1_MASTER: g = `IPCB_GRP_4;
            SRC_I2C1_SLAVE: g = `IPCB_GRP_4;
            SRC_CAPTURE8: g = `IPCB_GRP_5;
            SRC_CAPTURE7: g = `IPCB_GRP_5;
            SRC_EXT_IRQ1: g = `IPCB_GRP_5;
            SRC_TIMER4: g = `IPCB_GRP_6;
            SRC_COMPARE4: g = `IPCB_GRP_6;
            SRC_COMPARE3: g = `IPCB_GRP_6;
            SRC_DMA_CH2_DONE: g = `IPCB_GRP_6;
            default: g = `IPCB_GRP_2;
        endcase
        return g;
    endfunction

    // Lowest bit of a source's field within its register
    function automatic logic [3:0] src_lsb(input int idx);
        logic [3:0] b;
        b = `IPCB_LSB_LO;
        case (ipcb_src_t'(idx))
            SRC_UART1_RX: b = `IPCB_LSB_HI;
            SRC_SPI1_EVENT: b = `IPCB_LSB_MH;
            SRC_SPI1_ERROR: b = `IPCB_LSB_ML;
            SRC_TIMER3: b = `IPCB_LSB_LO;
            SRC_DMA_CH1_DONE: b = `IPCB_LSB_MH;
            SRC_ADC1_DONE: b = `IPCB_LSB_ML;
            SRC_UART1_TX: b = `IPCB_LSB_LO;
            SRC_CHANGE_NOTIFY: b = `IPCB_LSB_HI;
            SRC_COMPARATOR: b = `IPCB_LSB_MH;
            SRC_I2C1_MASTER: b = `IPCB_LSB_ML;
            SRC_I2C1_SLAVE: b = `IPCB_LSB_LO;
            SRC_CAPTURE8: b = `IPCB_LSB_HI;
            SRC_CAPTURE7: b = `IPCB_LSB_MH;
            SRC_EXT_IRQ1: b = `IPCB_LSB_LO;
            SRC_TIMER4: b = `IPCB_LSB_HI;
            SRC_COMPARE4: b = `IPCB_LSB_MH;
            SRC_COMPARE3: b = `IPCB_LSB_ML;
            SRC_DMA_CH2_DONE: b = `IPCB_LSB_LO;
            default: b = `IPCB_LSB_LO;
        endcase
        return b;
    endfunction

    // Implemented-bit mask of a group slot
    function automatic logic [15:0] grp_mask(input logic [2:0] g);
        logic [15:0] m;
        m = 16'h0000;
        case (g)
            `IPCB_GRP_2: m = `IPCB_MASK_GRP2;
            `IPCB_GRP_3: m = `IPCB_MASK_GRP3;
            `IPCB_GRP_4: m = `IPCB_MASK_GRP4;
            `IPCB_GRP_5: m = `IPCB_MASK_GRP5;
            `IPCB_GRP_6: m = `IPCB_MASK_GRP6;
            default: m = 16'h0000;
        endcase
        return m;
    endfunction

    // =====================================================
    // Address decode

    // One hit line per register; anything else is unmapped
    assign grp_hit[`IPCB_GRP_2] = (i_addr == `IPCB_ADDR_GRP2);
    assign grp_hit[`IPCB_GRP_3] = (i_addr == `IPCB_ADDR_GRP3);
    assign grp_hit[`IPCB_GRP_4] = (i_addr == `IPCB_ADDR_GRP4);
    assign grp_hit[`IPCB_GRP_5] = (i_addr == `IPCB_ADDR_GRP5);
    assign grp_hit[`IPCB_GRP_6] = (i_addr == `IPCB_ADDR_GRP6);
    assign act_lo_hit = (i_addr == `IPCB_ADDR_ACT_LO);
    assign act_hi_hit = (i_addr == `IPCB_ADDR_ACT_HI);

    // =====================================================
    // Fields and their presentation to the arbiter

    // Each field takes only its own three data bits, so gap bits are lost
    for (genvar i = 0; i < `IPCB_NUM_SRC; i++) begin : g_src
        logic fld_wr;
        ipcb_level_t fld_wdata;

        // Write strobe and data bits of this one field; the active map
        // addresses hit no field, so writes there change nothing
        assign fld_wr = i_wr & grp_hit[src_grp(i)];
        assign fld_wdata = i_wdata[src_lsb(i) +: 3];

        ipcb_field u_field (
            .i_clk(i_clk),
            .i_reset(i_reset),
            .i_wr(fld_wr),
            .i_wdata(fld_wdata),
            .o_level(fld_level[i])
        );

        // Level and enable follow the field on every clock
        // The extra stage keeps every arbiter-facing output on a flip-flop
        ipcb_gate u_gate (
            .i_clk(i_clk),
            .i_reset(i_reset),
            .i_level(fld_level[i]),
            .o_level(out_level[i]),
            .o_active(out_active[i])
        );
    end

    // =====================================================
    // Read-back images

    // Group 2: four fields, zero gaps
    assign img[`IPCB_GRP_2] = {1'b0, fld_level[SRC_UART1_RX],
                               1'b0, fld_level[SRC_SPI1_EVENT],
                               1'b0, fld_level[SRC_SPI1_ERROR],
                               1'b0, fld_level[SRC_TIMER3]}
                              & grp_mask(`IPCB_GRP_2);

    // Group 3: upper five bits empty
    assign img[`IPCB_GRP_3] = {5'h00, fld_level[SRC_DMA_CH1_DONE],
                               1'b0, fld_level[SRC_ADC1_DONE],
                               1'b0, fld_level[SRC_UART1_TX]}
                              & grp_mask(`IPCB_GRP_3);

    // Group 4: four fields, zero gaps
    assign img[`IPCB_GRP_4] = {1'b0, fld_level[SRC_CHANGE_NOTIFY],
                               1'b0, fld_level[SRC_COMPARATOR],
                               1'b0, fld_level[SRC_I2C1_MASTER],
                               1'b0, fld_level[SRC_I2C1_SLAVE]}
                              & grp_mask(`IPCB_GRP_4);

    // Group 5: bits 7 to 3 empty
    assign img[`IPCB_GRP_5] = {1'b0, fld_level[SRC_CAPTURE8],
                               1'b0, fld_level[SRC_CAPTURE7],
                               5'h00, fld_level[SRC_EXT_IRQ1]}
                              & grp_mask(`IPCB_GRP_5);

    // Group 6: four fields, zero gaps
    assign img[`IPCB_GRP_6] = {1'b0, fld_level[SRC_TIMER4],
                               1'b0, fld_level[SRC_COMPARE4],
                               1'b0, fld_level[SRC_COMPARE3],
                               1'b0, fld_level[SRC_DMA_CH2_DONE]}
                              & grp_mask(`IPCB_GRP_6);

    // Active map as presented, in source order
    // Sources 16 and 17 fill the low bits of the second word
    assign act_lo_word = out_active[15:0];
    assign act_hi_word = {14'h0, out_active[17:16]};

    // =====================================================
    // Read path

    // Select the addressed word; unmapped reads give zero
    // Hit lines are one-hot, so the order of the chain does not matter
    assign rd_word = grp_hit[`IPCB_GRP_2] ? img[`IPCB_GRP_2] :
                     grp_hit[`IPCB_GRP_3] ? img[`IPCB_GRP_3] :
                     grp_hit[`IPCB_GRP_4] ? img[`IPCB_GRP_4] :
                     grp_hit[`IPCB_GRP_5] ? img[`IPCB_GRP_5] :
                     grp_hit[`IPCB_GRP_6] ? img[`IPCB_GRP_6] :
                     act_lo_hit ? act_lo_word :
                     act_hi_hit ? act_hi_word :
                     `IPCB_RDATA_IDLE;

    // Data stand only in the cycle after the strobe
    // Zero between reads keeps stale words off the bus and lets a
    // wired-OR of several banks work without a select
    assign rdata_d = i_rd ? rd_word : `IPCB_RDATA_IDLE;

    // Read data register
    // Cleared by reset so the first cycles after release read as zero
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rdata_q <= `IPCB_RDATA_IDLE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;

    // =====================================================
    // Output levels, one per source

    // Group 2 sources
    assign o_uart1_rx_level = out_level[SRC_UART1_RX];
    assign o_spi1_event_level = out_level[SRC_SPI1_EVENT];
    assign o_spi1_error_level = out_level[SRC_SPI1_ERROR];
    assign o_timer3_level = out_level[SRC_TIMER3];

    // Group 3 sources
    assign o_dma_ch1_done_level = out_level[SRC_DMA_CH1_DONE];
    assign o_adc1_done_level = out_level[SRC_ADC1_DONE];
    assign o_uart1_tx_level = out_level[SRC_UART1_TX];

    // Group 4 sources
    assign o_change_notify_level = out_level[SRC_CHANGE_NOTIFY];
    assign o_comparator_level = out_level[SRC_COMPARATOR];
    assign o_i2c1_master_level = out_level[SRC_I2C1_MASTER];
    assign o_i2c1_slave_level = out_level[SRC_I2C1_SLAVE];

    // Group 5 sources
    assign o_capture8_level = out_level[SRC_CAPTURE8];
    assign o_capture7_level = out_level[SRC_CAPTURE7];
    assign o_ext_irq1_level = out_level[SRC_EXT_IRQ1];

    // Group 6 sources
    assign o_timer4_level = out_level[SRC_TIMER4];
    assign o_compare4_level = out_level[SRC_COMPARE4];
    assign o_compare3_level = out_level[SRC_COMPARE3];
    assign o_dma_ch2_done_level = out_level[SRC_DMA_CH2_DONE];

    // =====================================================
    // Output enables, low when the field is zero

    // Group 2 sources
    assign o_uart1_rx_active = out_active[SRC_UART1_RX];
    assign o_spi1_event_active = out_active[SRC_SPI1_EVENT];
    assign o_spi1_error_active = out_active[SRC_SPI1_ERROR];
    assign o_timer3_active = out_active[SRC_TIMER3];

    // Group 3 sources
    assign o_dma_ch1_done_active = out_active[SRC_DMA_CH1_DONE];
    assign o_adc1_done_active = out_active[SRC_ADC1_DONE];
    assign o_uart1_tx_active = out_active[SRC_UART1_TX];

    // Group 4 sources
    assign o_change_notify_active = out_active[SRC_CHANGE_NOTIFY];
    assign o_comparator_active = out_active[SRC_COMPARATOR];
    assign o_i2c1_master_active = out_active[SRC_I2C1_MASTER];
    assign o_i2c1_slave_active = out_active[SRC_I2C1_SLAVE];

    // Group 5 sources
    assign o_capture8_active = out_active[SRC_CAPTURE8];
    assign o_capture7_active = out_active[SRC_CAPTURE7];
    assign o_ext_irq1_active = out_active[SRC_EXT_IRQ1];

    // Group 6 sources
    assign o_timer4_active = out_active[SRC_TIMER4];
    assign o_compare4_active = out_active[SRC_COMPARE4];
    assign o_compare3_active = out_active[SRC_COMPARE3];
    assign o_dma_ch2_done_active = out_active[SRC_DMA_CH2_DONE];

endmodule
